//--- osprd_pkg.sv
// Purpose: shared constants and types for the octal serial port register decoder
// Assumes: word address from A1..A6, byte-wide data on the low lane
// Notes:   offsets are word indices inside one port block
package osprd_pkg;

  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned PORT_W      = 3;
  localparam int unsigned OFS_W       = 3;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned BUS_W       = 16;
  localparam int unsigned NUM_PORTS   = 8;
  localparam int unsigned PORT_BYTES  = 16;
  localparam int unsigned WAIT_W      = 2;

  // word offset inside a port block (byte offset / 2)
  localparam logic [OFS_W-1:0] OFS_DATA     = 3'h0;
  localparam logic [OFS_W-1:0] OFS_IEN      = 3'h1;
  localparam logic [OFS_W-1:0] OFS_ISTAT    = 3'h2;
  localparam logic [OFS_W-1:0] OFS_LFMT     = 3'h3;
  localparam logic [OFS_W-1:0] OFS_HSCTL    = 3'h4;
  localparam logic [OFS_W-1:0] OFS_LSTAT    = 3'h5;
  localparam logic [OFS_W-1:0] OFS_HSSTAT   = 3'h6;
  localparam logic [OFS_W-1:0] OFS_SCRATCH  = 3'h7;

  localparam int unsigned      DIV_LATCH_BIT = 7;
  localparam logic [DATA_W-1:0] ENH_BANK_CODE = 8'hbf;
  localparam logic [DATA_W-1:0] LFMT_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO     = 8'h00;

  // wait states per cycle kind
  localparam logic [WAIT_W-1:0] WAIT_IO  = 2'h1;
  localparam logic [WAIT_W-1:0] WAIT_INT = 2'h2;
  localparam logic [WAIT_W-1:0] WAIT_ID  = 2'h0;

  typedef enum logic [17:0] {
    OSPRD_SEL_NONE      = 18'h00001,
    OSPRD_SEL_RECV      = 18'h00002,
    OSPRD_SEL_XMIT      = 18'h00004,
    OSPRD_SEL_DIV_LO    = 18'h00008,
    OSPRD_SEL_DIV_HI    = 18'h00010,
    OSPRD_SEL_INT_EN    = 18'h00020,
    OSPRD_SEL_INT_STAT  = 18'h00040,
    OSPRD_SEL_QUEUE     = 18'h00080,
    OSPRD_SEL_ENH       = 18'h00100,
    OSPRD_SEL_LINE_FMT  = 18'h00200,
    OSPRD_SEL_HS_CTL    = 18'h00400,
    OSPRD_SEL_LINE_STAT = 18'h00800,
    OSPRD_SEL_HS_STAT   = 18'h01000,
    OSPRD_SEL_SCRATCH   = 18'h02000,
    OSPRD_SEL_RESUME_LO = 18'h04000,
    OSPRD_SEL_RESUME_HI = 18'h08000,
    OSPRD_SEL_PAUSE_LO  = 18'h10000,
    OSPRD_SEL_PAUSE_HI  = 18'h20000
  } osprd_sel_type;

  typedef enum logic [3:0] {
    OSPRD_ST_IDLE = 4'h1,
    OSPRD_ST_WAIT = 4'h2,
    OSPRD_ST_ACK  = 4'h4,
    OSPRD_ST_HOLD = 4'h8
  } osprd_state_type;

  typedef enum logic [2:0] {
    OSPRD_KIND_IO  = 3'h1,
    OSPRD_KIND_INT = 3'h2,
    OSPRD_KIND_ID  = 3'h4
  } osprd_kind_type;

endpackage

//--- osprd_decoder.sv
// Purpose: I/O space decoder for eight identical serial port register blocks
// Assumes: bus inputs synchronous to i_mclk; engines answer reads in the strobe cycle
// Notes:   line format registers live here, all other registers in the port engines
// Operation
// - transfers carry eight meaningful bits on D0..D7 only, no wider access.
// - six word-address lines decode 64 word locations, low byte lane only.
// - low byte sits at odd byte addresses big-endian, even ones little-endian.
// - eight identical port blocks stepping by 0x10 from 00 to 70.
// - the divisor bytes appear only while the port's line format bit 7 is one.
// - enhanced and flow-control character registers appear only at line format BF.
// - shared offsets pick by address, line format and direction (00 data, 04 status/queue).
// - line format sits at byte offset 06; port address is port A offset plus block offset.
// - the upper data byte is never driven, so carrier pull-ups read it as ones.
// - I/O cycles take one wait state, interrupt select two, identification reads zero.
// - each port owns a sixteen-byte block with no overlap.
`timescale 1ns/100ps
module osprd_decoder (
  input  wire logic                                i_mclk,
  input  wire logic                                i_rst_b,
  input  wire logic                                i_ce,
  input  wire logic                                i_iosel_b,
  input  wire logic                                i_intsel_b,
  input  wire logic                                i_idsel_b,
  input  wire logic                                i_rd_wr_b,
  input  wire logic [osprd_pkg::ADDR_W-1:0]        i_addr,
  input  wire logic [osprd_pkg::DATA_W-1:0]        i_wr_data,
  input  wire logic [osprd_pkg::DATA_W-1:0]        i_eng_rd_data,
  input  wire logic [osprd_pkg::DATA_W-1:0]        i_int_vector,
  input  wire logic [osprd_pkg::DATA_W-1:0]        i_id_data,
  output logic      [osprd_pkg::DATA_W-1:0]        o_data,
  output logic                                     o_data_oe,
  output logic                                     o_ack_b,
  output logic      [osprd_pkg::PORT_W-1:0]        o_port,
  output osprd_pkg::osprd_sel_type                 o_reg_sel,
  output logic                                     o_rd_stb,
  output logic                                     o_wr_stb,
  output logic      [osprd_pkg::DATA_W-1:0]        o_wr_data
);

  osprd_pkg::osprd_state_type              state_reg;
  osprd_pkg::osprd_kind_type               kind_reg;
  osprd_pkg::osprd_kind_type               kind_next;
  osprd_pkg::osprd_sel_type                sel_next;
  logic [osprd_pkg::WAIT_W-1:0]            wait_reg;
  logic [osprd_pkg::WAIT_W-1:0]            wait_next;
  logic                                    read_reg;
  logic [osprd_pkg::DATA_W-1:0]            lfmt_reg [osprd_pkg::NUM_PORTS];
  logic [osprd_pkg::DATA_W-1:0]            port_lfmt;
  logic [osprd_pkg::PORT_W-1:0]            port_next;
  logic [osprd_pkg::OFS_W-1:0]             ofs_next;
  logic [osprd_pkg::DATA_W-1:0]            rd_mux;
  logic                                    any_sel;
  logic                                    bank_div;
  logic                                    bank_enh;
  logic                                    start;
  logic                                    go_ack;

  assign any_sel   = ~i_iosel_b | ~i_intsel_b | ~i_idsel_b;
  // upper three word-address bits pick the block, lower three the word
  assign port_next = i_addr[osprd_pkg::ADDR_W-1:osprd_pkg::OFS_W];
  assign ofs_next  = i_addr[osprd_pkg::OFS_W-1:0];
  // only the addressed port's own banking counts
  assign port_lfmt = lfmt_reg[port_next];
  assign bank_enh  = (port_lfmt == osprd_pkg::ENH_BANK_CODE);
  assign bank_div  = port_lfmt[osprd_pkg::DIV_LATCH_BIT];
  assign start     = (state_reg == osprd_pkg::OSPRD_ST_IDLE) & any_sel;

  // kind and wait count; io wins if several selects collide
  always_comb begin
    if (~i_iosel_b) begin
      kind_next = osprd_pkg::OSPRD_KIND_IO;
      wait_next = osprd_pkg::WAIT_IO;
    end else if (~i_intsel_b) begin
      kind_next = osprd_pkg::OSPRD_KIND_INT;
      wait_next = osprd_pkg::WAIT_INT;
    end else begin
      kind_next = osprd_pkg::OSPRD_KIND_ID;
      wait_next = osprd_pkg::WAIT_ID;
    end
  end

  // register pick; BF also has bit 7 set, so offsets 0 and 1 stay divisor, offset 3 stays line format and only 2 and 4 to 7 take the enhanced bank
  always_comb begin
    sel_next = osprd_pkg::OSPRD_SEL_NONE;
    case (ofs_next)
      osprd_pkg::OFS_DATA: begin
        if (bank_div) sel_next = osprd_pkg::OSPRD_SEL_DIV_LO;
        else if (i_rd_wr_b) sel_next = osprd_pkg::OSPRD_SEL_RECV;
        else sel_next = osprd_pkg::OSPRD_SEL_XMIT;
      end
      osprd_pkg::OFS_IEN: begin
        if (bank_div) sel_next = osprd_pkg::OSPRD_SEL_DIV_HI;
        else sel_next = osprd_pkg::OSPRD_SEL_INT_EN;
      end
      osprd_pkg::OFS_ISTAT: begin
        if (bank_enh) sel_next = osprd_pkg::OSPRD_SEL_ENH;
        else if (i_rd_wr_b) sel_next = osprd_pkg::OSPRD_SEL_INT_STAT;
        else sel_next = osprd_pkg::OSPRD_SEL_QUEUE;
      end
      osprd_pkg::OFS_LFMT: sel_next = osprd_pkg::OSPRD_SEL_LINE_FMT;
      osprd_pkg::OFS_HSCTL: begin
        if (bank_enh) sel_next = osprd_pkg::OSPRD_SEL_RESUME_LO;
        else sel_next = osprd_pkg::OSPRD_SEL_HS_CTL;
      end
      osprd_pkg::OFS_LSTAT: begin
        if (bank_enh) sel_next = osprd_pkg::OSPRD_SEL_RESUME_HI;
        else sel_next = osprd_pkg::OSPRD_SEL_LINE_STAT;
      end
      osprd_pkg::OFS_HSSTAT: begin
        if (bank_enh) sel_next = osprd_pkg::OSPRD_SEL_PAUSE_LO;
        else sel_next = osprd_pkg::OSPRD_SEL_HS_STAT;
      end
      osprd_pkg::OFS_SCRATCH: begin
        if (bank_enh) sel_next = osprd_pkg::OSPRD_SEL_PAUSE_HI;
        else sel_next = osprd_pkg::OSPRD_SEL_SCRATCH;
      end
      default: sel_next = osprd_pkg::OSPRD_SEL_NONE;
    endcase
  end

  assign go_ack = (state_reg == osprd_pkg::OSPRD_ST_WAIT) &&
                  (wait_reg == osprd_pkg::WAIT_ID);

  // cycle sequencer; hold waits for the host to drop its select
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state_reg <= osprd_pkg::OSPRD_ST_IDLE;
      wait_reg  <= osprd_pkg::WAIT_ID;
      kind_reg  <= osprd_pkg::OSPRD_KIND_IO;
      read_reg  <= 1'b0;
    end else if (i_ce) begin
      case (state_reg)
        osprd_pkg::OSPRD_ST_IDLE: begin
          if (any_sel) begin
            kind_reg  <= kind_next;
            read_reg  <= i_rd_wr_b;
            wait_reg  <= wait_next - 2'h1;
            if (wait_next == osprd_pkg::WAIT_ID) state_reg <= osprd_pkg::OSPRD_ST_ACK;
            else state_reg <= osprd_pkg::OSPRD_ST_WAIT;
          end
        end
        osprd_pkg::OSPRD_ST_WAIT: begin
          if (go_ack) state_reg <= osprd_pkg::OSPRD_ST_ACK;
          else wait_reg <= wait_reg - 2'h1;
        end
        osprd_pkg::OSPRD_ST_ACK: state_reg <= osprd_pkg::OSPRD_ST_HOLD;
        osprd_pkg::OSPRD_ST_HOLD: begin
          if (!any_sel) state_reg <= osprd_pkg::OSPRD_ST_IDLE;
        end
        default: state_reg <= osprd_pkg::OSPRD_ST_IDLE;
      endcase
    end
  end

  // address and strobes toward the port engines
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_port    <= '0;
      o_reg_sel <= osprd_pkg::OSPRD_SEL_NONE;
      o_rd_stb  <= 1'b0;
      o_wr_stb  <= 1'b0;
      o_wr_data <= osprd_pkg::DATA_ZERO;
    end else if (i_ce) begin
      o_rd_stb <= start & ~i_iosel_b & i_rd_wr_b;
      o_wr_stb <= start & ~i_iosel_b & ~i_rd_wr_b;
      if (start) begin
        o_port    <= port_next;
        o_reg_sel <= (~i_iosel_b) ? sel_next : osprd_pkg::OSPRD_SEL_NONE;
        o_wr_data <= i_wr_data;
      end
    end
  end

  // line format copies, one per port block
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      for (int p = 0; p < osprd_pkg::NUM_PORTS; p++) lfmt_reg[p] <= osprd_pkg::LFMT_RESET;
    end else if (i_ce) begin
      if (start && !i_iosel_b && !i_rd_wr_b && sel_next == osprd_pkg::OSPRD_SEL_LINE_FMT) begin
        lfmt_reg[port_next] <= i_wr_data;
      end
    end
  end

  always_comb begin
    rd_mux = i_id_data;
    case (kind_reg)
      osprd_pkg::OSPRD_KIND_IO: begin
        if (o_reg_sel == osprd_pkg::OSPRD_SEL_LINE_FMT) rd_mux = lfmt_reg[o_port];
        else rd_mux = i_eng_rd_data;
      end
      osprd_pkg::OSPRD_KIND_INT: rd_mux = i_int_vector;
      osprd_pkg::OSPRD_KIND_ID:  rd_mux = i_id_data;
      default:                   rd_mux = i_id_data;
    endcase
  end

  // answer: only the low lane is ever enabled, upper byte left to pull-ups
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_data    <= osprd_pkg::DATA_ZERO;
      o_data_oe <= 1'b0;
      o_ack_b   <= 1'b1;
    end else if (i_ce) begin
      o_ack_b   <= 1'b1;
      o_data_oe <= 1'b0;
      if (start && wait_next == osprd_pkg::WAIT_ID) begin
        // zero-wait identification read served straight from the inputs
        o_ack_b   <= 1'b0;
        o_data_oe <= i_rd_wr_b;
        o_data    <= i_id_data;
      end else if (go_ack) begin
        o_ack_b   <= 1'b0;
        o_data_oe <= read_reg;
        o_data    <= rd_mux;
      end
    end
  end

endmodule

//--- osprd_decoder_chk.sv
// Purpose: port-level checks on the register decoder
// Assumes: clock enable held high
// Notes:   strobe cycle precedes the ack cycle by one clock
`timescale 1ns/100ps
module osprd_decoder_chk (
  input wire logic                     i_mclk,
  input wire logic                     i_rst_b,
  input wire logic                     i_iosel_b,
  input wire logic                     i_rd_wr_b,
  input wire logic [5:0]               i_addr,
  input wire logic [7:0]               i_wr_data,
  input wire logic [7:0]               i_eng_rd_data,
  input wire logic [7:0]               o_data,
  input wire logic                     o_data_oe,
  input wire logic                     o_ack_b,
  input wire logic [2:0]               o_port,
  input osprd_pkg::osprd_sel_type      o_reg_sel,
  input wire logic                     o_rd_stb,
  input wire logic                     o_wr_stb,
  input wire logic [7:0]               o_wr_data
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  logic [5:0] addr_q;
  always_ff @(posedge i_mclk) addr_q <= i_addr;
  sequence s_rd_ack;
    !o_ack_b && o_data_oe ##1 o_ack_b;
  endsequence
  a_ack_one_cycle: assert property (!o_ack_b |=> o_ack_b) else $error("ack too long");
  a_rd_ack_timing: assert property (o_rd_stb |=> s_rd_ack) else $error("read ack late");
  a_wr_ack_timing: assert property (o_wr_stb |=> !o_ack_b && !o_data_oe) else $error("wr ack");
  a_oe_only_ack: assert property (o_data_oe |-> !o_ack_b) else $error("stray drive");
  a_rd_from_io: assert property (o_rd_stb |-> $past(i_rd_wr_b) && !$past(i_iosel_b))
    else $error("bad read strobe");
  a_wr_data_pass: assert property (o_wr_stb |-> o_wr_data == $past(i_wr_data)
    && !$past(i_rd_wr_b)) else $error("bad write data");
  a_port_block: assert property ((o_rd_stb || o_wr_stb) |-> o_port == addr_q[5:3])
    else $error("bad port");
  a_lfmt_offset: assert property ((o_rd_stb || o_wr_stb) && addr_q[2:0] == 3'h3
    |-> o_reg_sel == osprd_pkg::OSPRD_SEL_LINE_FMT) else $error("bad lfmt sel");
  a_eng_rd_data: assert property (o_rd_stb && o_reg_sel != osprd_pkg::OSPRD_SEL_LINE_FMT
    |=> o_data == $past(i_eng_rd_data)) else $error("bad read data");
endmodule
bind osprd_decoder osprd_decoder_chk chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
  .i_iosel_b(i_iosel_b), .i_rd_wr_b(i_rd_wr_b), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .i_eng_rd_data(i_eng_rd_data), .o_data(o_data), .o_data_oe(o_data_oe), .o_ack_b(o_ack_b),
  .o_port(o_port), .o_reg_sel(o_reg_sel), .o_rd_stb(o_rd_stb), .o_wr_stb(o_wr_stb),
  .o_wr_data(o_wr_data));

//--- osprd_host_bfm.sv
// Purpose: carrier host bus controller model
// Assumes: big-endian host, byte cycles on odd addresses
// Notes:   released lines show inverted values
`timescale 1ns/100ps
module osprd_host_bfm (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_data,
  input  wire logic       i_data_oe,
  input  wire logic       i_ack_b,
  output logic            o_iosel_b,
  output logic            o_intsel_b,
  output logic            o_idsel_b,
  output logic            o_rd_wr_b,
  output logic [5:0]      o_addr,
  output logic [7:0]      o_wr_data
);
  logic [15:0] bus_d;
  assign bus_d = {8'hff, i_data_oe ? i_data : 8'hff};
  initial begin
    {o_iosel_b, o_intsel_b, o_idsel_b, o_rd_wr_b} = 4'hf;
    o_addr = 6'h00;
    o_wr_data = 8'h00;
  end
  // kind 0 io, 1 interrupt select, 2 identification
  task automatic xfer(input int kind, input logic rd, input logic [6:0] ba,
                      input logic [7:0] wd, output logic [7:0] rd_d, output int n);
    @(negedge i_mclk);
    o_addr = ba[6:1];
    o_rd_wr_b = rd;
    o_wr_data = wd;
    {o_iosel_b, o_intsel_b, o_idsel_b} = ~(3'h4 >> kind);
    n = 0;
    rd_d = 8'h00;
    for (int k = 1; k < 8 && n == 0; k++) begin
      @(negedge i_mclk);
      if (i_ack_b === 1'b0) begin
        n = k;
        rd_d = bus_d[7:0];
      end
    end
    @(negedge i_mclk);
    {o_iosel_b, o_intsel_b, o_idsel_b} = 3'h7;
    o_addr = ~o_addr;
    o_wr_data = ~o_wr_data;
    @(negedge i_mclk);
  endtask
endmodule

//--- tb_octal_serial_port_register_decode.sv
// Purpose: directed register decode tests
// Assumes: clock enable tied high
// Notes:   engine returns port number and a fixed code
`timescale 1ns/100ps
module tb_octal_serial_port_register_decode;
  logic                     i_mclk, i_rst_b, iosel_b, intsel_b, idsel_b, rd_wr_b;
  logic [5:0]               addr;
  logic [7:0]               wr_data, eng_d, o_data, o_wr_data, rdv;
  logic                     o_data_oe, o_ack_b, o_rd_stb, o_wr_stb;
  logic [2:0]               o_port;
  osprd_pkg::osprd_sel_type o_reg_sel, seen_sel;
  osprd_pkg::osprd_sel_type bf_sel [7];
  logic [2:0]               bf_ofs [7];
  int                       miscompares, total_checks, n, rd_cnt, wr_cnt;
  assign eng_d = {o_port, 5'h0a};
  // strobe counters catch a missing or doubled strobe that a stale select would hide
  always @(posedge i_mclk) begin
    if (o_rd_stb || o_wr_stb) seen_sel <= o_reg_sel;
    if (o_rd_stb) rd_cnt <= rd_cnt + 1;
    if (o_wr_stb) wr_cnt <= wr_cnt + 1;
  end
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  osprd_decoder dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_iosel_b(iosel_b),
    .i_intsel_b(intsel_b), .i_idsel_b(idsel_b), .i_rd_wr_b(rd_wr_b), .i_addr(addr),
    .i_wr_data(wr_data), .i_eng_rd_data(eng_d), .i_int_vector(8'h5a),
    .i_id_data({2'h0, addr}), .o_data(o_data), .o_data_oe(o_data_oe), .o_ack_b(o_ack_b),
    .o_port(o_port), .o_reg_sel(o_reg_sel), .o_rd_stb(o_rd_stb), .o_wr_stb(o_wr_stb),
    .o_wr_data(o_wr_data));
  osprd_host_bfm host (.i_mclk(i_mclk), .i_data(o_data), .i_data_oe(o_data_oe),
    .i_ack_b(o_ack_b), .o_iosel_b(iosel_b), .o_intsel_b(intsel_b), .o_idsel_b(idsel_b),
    .o_rd_wr_b(rd_wr_b), .o_addr(addr), .o_wr_data(wr_data));
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [17:0] exp, input logic [17:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // io access; engine data expected on reads except the locally held line format
  task automatic acc(input logic [2:0] p, input logic [2:0] ofs, input logic rd,
                     input logic [7:0] wd, input osprd_pkg::osprd_sel_type es);
    int r0, w0;
    r0 = rd_cnt;
    w0 = wr_cnt;
    host.xfer(0, rd, {p, ofs, 1'b1}, wd, rdv, n);
    if (n == 0) begin
      miscompares++;
      close_out();
    end
    cmp("io wait", 18'h2, 18'(n));
    cmp("reg select", es, seen_sel);
    cmp("read strobes", 18'(rd), 18'(rd_cnt - r0));
    cmp("write strobes", 18'(!rd), 18'(wr_cnt - w0));
    if (rd && es != osprd_pkg::OSPRD_SEL_LINE_FMT) begin
      cmp("read data", 18'({p, 5'h0a}), 18'(rdv));
    end
    if (!rd) cmp("write lane idle", 18'hff, 18'(rdv));
  endtask
  initial begin
    bf_ofs = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    bf_sel = '{osprd_pkg::OSPRD_SEL_DIV_LO, osprd_pkg::OSPRD_SEL_DIV_HI,
      osprd_pkg::OSPRD_SEL_ENH, osprd_pkg::OSPRD_SEL_RESUME_LO, osprd_pkg::OSPRD_SEL_RESUME_HI,
      osprd_pkg::OSPRD_SEL_PAUSE_LO, osprd_pkg::OSPRD_SEL_PAUSE_HI};
    i_rst_b = 1'b0;
    repeat (8) @(negedge i_mclk);
    i_rst_b = 1'b1;
    for (int p = 0; p < 8; p++) begin
      acc(3'(p), 3'h3, 1'b1, 8'h00, osprd_pkg::OSPRD_SEL_LINE_FMT);
      cmp("lfmt reset", 18'h0, 18'(rdv));
    end
    acc(3'h2, 3'h3, 1'b0, 8'h80, osprd_pkg::OSPRD_SEL_LINE_FMT);
    acc(3'h2, 3'h3, 1'b1, 8'h00, osprd_pkg::OSPRD_SEL_LINE_FMT);
    cmp("lfmt readback", 18'h80, 18'(rdv));
    acc(3'h2, 3'h0, 1'b1, 8'h00, osprd_pkg::OSPRD_SEL_DIV_LO);
    acc(3'h2, 3'h1, 1'b0, 8'h11, osprd_pkg::OSPRD_SEL_DIV_HI);
    acc(3'h3, 3'h0, 1'b1, 8'h00, osprd_pkg::OSPRD_SEL_RECV);
    acc(3'h3, 3'h1, 1'b1, 8'h00, osprd_pkg::OSPRD_SEL_INT_EN);
    acc(3'h5, 3'h3, 1'b0, 8'hbf, osprd_pkg::OSPRD_SEL_LINE_FMT);
    for (int i = 0; i < 7; i++) acc(3'h5, bf_ofs[i], 1'b1, 8'h00, bf_sel[i]);
    acc(3'h5, 3'h3, 1'b0, 8'hbe, osprd_pkg::OSPRD_SEL_LINE_FMT);
    acc(3'h5, 3'h0, 1'b1, 8'h00, osprd_pkg::OSPRD_SEL_DIV_LO);
    acc(3'h5, 3'h2, 1'b1, 8'h00, osprd_pkg::OSPRD_SEL_INT_STAT);
    acc(3'h5, 3'h2, 1'b0, 8'h33, osprd_pkg::OSPRD_SEL_QUEUE);
    acc(3'h5, 3'h3, 1'b0, 8'h00, osprd_pkg::OSPRD_SEL_LINE_FMT);
    acc(3'h5, 3'h0, 1'b0, 8'h44, osprd_pkg::OSPRD_SEL_XMIT);
    acc(3'h5, 3'h4, 1'b1, 8'h00, osprd_pkg::OSPRD_SEL_HS_CTL);
    acc(3'h5, 3'h5, 1'b1, 8'h00, osprd_pkg::OSPRD_SEL_LINE_STAT);
    acc(3'h5, 3'h6, 1'b1, 8'h00, osprd_pkg::OSPRD_SEL_HS_STAT);
    acc(3'h5, 3'h7, 1'b0, 8'h66, osprd_pkg::OSPRD_SEL_SCRATCH);
    acc(3'h7, 3'h0, 1'b1, 8'h00, osprd_pkg::OSPRD_SEL_RECV);
    host.xfer(2, 1'b1, 7'h0b, 8'h00, rdv, n);
    cmp("id wait", 18'h1, 18'(n));
    cmp("id data", 18'h05, 18'(rdv));
    host.xfer(1, 1'b1, 7'h01, 8'h00, rdv, n);
    cmp("int wait", 18'h3, 18'(n));
    cmp("int vector", 18'h5a, 18'(rdv));
    close_out();
  end
endmodule
